//--- hw/atd_pkg.sv
package atd_pkg;

    // ------------------------------------------------------------
    // Data widths
    // ------------------------------------------------------------
    localparam int DATA_W   = 16;               // Conversion result width
    localparam int SENS_W   = 8;                // Sensitivity width
    localparam int DAC_W    = 6;                // Offset DAC code width
    localparam int SETL_W   = 4;                // Settling shift width
    localparam int TOUT_W   = 4;                // Timeout count width
    localparam int SENS_LSB = 4;                // 12-bit LSB sits at bit 4 of 16

    // ------------------------------------------------------------
    // Auto DAC limits and steps
    // ------------------------------------------------------------
    localparam logic [15:0] AVG_HIGH_LIMIT = 16'hA800;  // Increment above
    localparam logic [15:0] AVG_LOW_LIMIT  = 16'h5800;  // Decrement below
    localparam logic [5:0]  DAC_FULL       = 6'h3F;     // Full-scale code
    localparam logic [5:0]  DAC_ZERO       = 6'h00;     // Bottom code
    localparam logic [5:0]  DAC_STEP_LO    = 6'h01;     // Step, low range
    localparam logic [5:0]  DAC_STEP_HI    = 6'h02;     // Step, high range
    localparam logic [15:0] AVG_RESET      = 16'h0000;  // Average after reset

    // ------------------------------------------------------------
    // Threshold direction modes
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        ATD_NEG    = 2'h0,   // Flag data below threshold
        ATD_POS    = 2'h1,   // Flag data above threshold
        ATD_IN_WIN = 2'h2,   // Flag data inside band
        ATD_OUT_WIN= 2'h3    // Flag data outside band
    } atd_dir_t;

    // Power-down timer constants
    localparam int PD_TIMER_W = 6;              // Power-down timeout width
    localparam int PD_UNIT_W  = 24;             // Prescaler width

endpackage

//--- hw/atd_offset_dac.sv
`timescale 1ns/1ps
`default_nettype none

// --------
// Automatic offset DAC tracker for one channel
// --------
module atd_offset_dac
(
    input  wire logic        mclk,           // System clock
    input  wire logic        srst,           // Synchronous reset
    input  wire logic        load,           // Load programmed code
    input  wire logic [5:0]  load_value,     // Programmed code
    input  wire logic        auto_en,        // Automatic tracking enable
    input  wire logic        step_now,       // One pulse per conversion
    input  wire logic        range_high,     // Selected input range
    input  wire logic [15:0] average,        // Current average
    output logic      [5:0]  dac_code        // Offset cancel code
);

    typedef struct packed
    {
        logic [5:0] code;                    // Current code
    } atd_dac_state_t;

    atd_dac_state_t cur;                     // Registered state
    atd_dac_state_t next_cur;                // Next state

    logic [5:0] step;                        // Step size for range
    logic [6:0] sum_up;                      // Increment with carry
    logic [6:0] sum_dn;                      // Decrement with borrow

    // --------
    // Next code
    // --------
    always_comb
    begin
        next_cur = cur;
        step     = range_high ? atd_pkg::DAC_STEP_HI : atd_pkg::DAC_STEP_LO; // [RULE14]
        sum_up   = {1'b0, cur.code} + {1'b0, step};
        sum_dn   = {1'b0, cur.code} - {1'b0, step};
        if (load)
        begin
            // Software code wins
            next_cur.code = load_value;
        end
        else if (auto_en && step_now)
        begin
            if (average > atd_pkg::AVG_HIGH_LIMIT && cur.code != atd_pkg::DAC_FULL) // [RULE12] [RULE15]
            begin
                // Saturate at full scale
                next_cur.code = sum_up[6] ? atd_pkg::DAC_FULL : sum_up[5:0];
            end
            else if (average < atd_pkg::AVG_LOW_LIMIT && cur.code != atd_pkg::DAC_ZERO) // [RULE13] [RULE15]
            begin
                // Saturate at zero
                next_cur.code = sum_dn[6] ? atd_pkg::DAC_ZERO : sum_dn[5:0];
            end
        end
    end

    // --------
    // State register
    // --------
    always_ff @(posedge mclk)
    begin
        if (srst)
            cur <= '0;
        else
            cur <= next_cur;
    end

    assign dac_code = cur.code;              // [RULE16]

endmodule

`default_nettype wire

//--- hw/atd_sync2.sv
`timescale 1ns/1ps
`default_nettype none

// --------
// Two flip-flop synchroniser for a level
// --------
module atd_sync2
(
    input  wire logic mclk,                  // System clock
    input  wire logic srst,                  // Synchronous reset
    input  wire logic din,                   // Asynchronous level
    output logic      dout                   // Synchronised level
);

    typedef struct packed
    {
        logic s1;                            // First stage
        logic s2;                            // Second stage
    } atd_sync_state_t;

    atd_sync_state_t cur;                    // Registered state
    atd_sync_state_t next_cur;               // Next state

    // Shift
    always_comb
    begin
        next_cur.s1 = din;
        next_cur.s2 = cur.s1;
    end

    // Register
    always_ff @(posedge mclk)
    begin
        if (srst)
            cur <= '0;
        else
            cur <= next_cur;
    end

    assign dout = cur.s2;

endmodule

`default_nettype wire

//--- hw/adaptive_threshold_detector.sv
// Behaviour
// RULE1 - Compare data to fixed or adaptive threshold
// RULE2 - Fixed mode: flag when data crosses threshold
// RULE3 - Positive or negative change selectable
// RULE4 - Adaptive only: inside or outside window
// RULE5 - Sensitivity 0..255 LSB around average
// RULE6 - Average += (data-average) >> (settling+1)
// RULE7 - Adaptive hysteresis is quarter sensitivity
// RULE8 - No hysteresis in fixed mode
// RULE9 - Timeout counts only outside average band
// RULE10 - Timeout expiry loads average with data
// RULE11 - Separate approach and recede timeouts
// RULE12 - Auto DAC increments above 0xA800
// RULE13 - Auto DAC decrements below 0x5800
// RULE14 - DAC step depends on input range
// RULE15 - DAC saturates at zero and full scale
// RULE16 - DAC is monotonic 6-bit code
// RULE17 - Inactivity timer triggers power-down
// RULE18 - Host command or power cycle wakes
// RULE19 - Detect pin high while proximity detected
// RULE20 - Independent state per channel
// RULE21 - Updates once per completed conversion
`timescale 1ns/1ps
`default_nettype none

module adaptive_threshold_detector
#(
    parameter int PD_UNIT_CYCLES = 25000     // Cycles per power-down tick
)
(
    input  wire logic        mclk,              // 25 MHz clock
    input  wire logic        srst,              // Synchronous reset
    input  wire logic [15:0] conv_data,         // Conversion result
    input  wire logic        conv_done,         // One pulse per result
    input  wire logic        conv_channel,      // 0 channel one, 1 channel two
    input  wire logic [1:0]  adaptive_en,       // Per channel adaptive mode
    input  wire logic [3:0]  dir_mode,          // Two bits per channel
    input  wire logic [15:0] fixed_threshold_one, // Fixed threshold ch one
    input  wire logic [15:0] fixed_threshold_two, // Fixed threshold ch two
    input  wire logic [7:0]  sensitivity_one,   // Sensitivity ch one
    input  wire logic [7:0]  sensitivity_two,   // Sensitivity ch two
    input  wire logic [3:0]  approach_timeout_one, // Approach count ch one
    input  wire logic [3:0]  approach_timeout_two, // Approach count ch two
    input  wire logic [3:0]  recede_timeout_one,   // Recede count ch one
    input  wire logic [3:0]  recede_timeout_two,   // Recede count ch two
    input  wire logic [3:0]  average_settling_shift_one, // Settling ch one
    input  wire logic [3:0]  average_settling_shift_two, // Settling ch two
    input  wire logic [1:0]  hyst_en,           // Per channel hysteresis
    input  wire logic [1:0]  range_high,        // Per channel input range
    input  wire logic [1:0]  dac_auto_en,       // Per channel auto DAC
    input  wire logic [1:0]  dac_load,          // Per channel code load
    input  wire logic [5:0]  dac_load_value_one, // Code for ch one
    input  wire logic [5:0]  dac_load_value_two, // Code for ch two
    input  wire logic        pd_timer_en,       // Power-down timer enable
    input  wire logic [5:0]  pd_timeout,        // Power-down interval ticks
    input  wire logic        host_wake,         // Asynchronous host command
    output logic             detect_flag_one,   // Detect pin ch one
    output logic             detect_flag_two,   // Detect pin ch two
    output logic [15:0]      average_one,       // Average ch one
    output logic [15:0]      average_two,       // Average ch two
    output logic [5:0]       offset_cancel_dac_one, // DAC code ch one
    output logic [5:0]       offset_cancel_dac_two, // DAC code ch two
    output logic             power_down         // Device asleep
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed
    {
        logic [1:0][15:0] avg;               // Per channel average
        logic [1:0][3:0]  tcount;            // Per channel timeout count
        logic [1:0]       flag;              // Per channel detect flag
        logic             pd;                // Powered down
        logic [23:0]      prescale;          // Tick prescaler
        logic [5:0]       idle_ticks;        // Ticks with no detection
    } atd_state_t;

    atd_state_t cur;                         // Registered state
    atd_state_t next_cur;                    // Next state

    logic        wake_sync;                  // Synchronised wake
    logic [1:0]  upd;                        // Per channel update strobe
    logic [1:0][15:0] fix_thr;               // Fixed thresholds
    logic [1:0][7:0]  sens;                  // Sensitivities
    logic [1:0][3:0]  appr;                  // Approach timeouts
    logic [1:0][3:0]  rec;                   // Recede timeouts
    logic [1:0][3:0]  shift;                 // Settling shifts
    logic [1:0][5:0]  dac_val;               // Programmed DAC codes
    logic [1:0][5:0]  dac_out;               // Live DAC codes

    assign fix_thr = {fixed_threshold_two, fixed_threshold_one};
    assign sens    = {sensitivity_two, sensitivity_one};
    assign appr    = {approach_timeout_two, approach_timeout_one};
    assign rec     = {recede_timeout_two, recede_timeout_one};
    assign shift   = {average_settling_shift_two, average_settling_shift_one};
    assign dac_val = {dac_load_value_two, dac_load_value_one};

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Sensitivity scaled to 16-bit data
    function automatic logic [17:0] scale_sens(input logic [7:0] s);
        scale_sens = 18'({s, 4'h0});
    endfunction

    // New average: signed step by 2^(shift+1)
    function automatic logic [15:0] avg_step(input logic [15:0] a, input logic [15:0] d,
                                             input logic [3:0] sh);
        logic signed [17:0] diff;
        logic signed [17:0] res;
        diff = $signed({2'b00, d}) - $signed({2'b00, a});
        res  = $signed({2'b00, a}) + (diff >>> (5'(sh) + 5'h01));
        avg_step = res[15:0];
    endfunction

    // Host wake passes two flip-flops
    atd_sync2 u_wake
    (
        .mclk (mclk),
        .srst (srst),
        .din  (host_wake),
        .dout (wake_sync)
    );

    // ------------------------------------------------------------
    // Per channel offset DAC trackers
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_dac
            atd_offset_dac u_dac
            (
                .mclk       (mclk),
                .srst       (srst),
                .load       (dac_load[gi]),
                .load_value (dac_val[gi]),
                .auto_en    (dac_auto_en[gi] & adaptive_en[gi]), // [RULE12]
                .step_now   (upd[gi]),                            // [RULE21]
                .range_high (range_high[gi]),
                .average    (cur.avg[gi]),
                .dac_code   (dac_out[gi])
            );
        end
    endgenerate

    // Update strobe per channel, blocked while asleep
    assign upd[0] = conv_done & ~conv_channel & ~cur.pd; // [RULE21]
    assign upd[1] = conv_done &  conv_channel & ~cur.pd; // [RULE21]

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        logic [17:0] d;
        logic [17:0] a;
        logic [17:0] s;
        logic [17:0] h;
        logic [17:0] up_t;
        logic [17:0] dn_t;
        logic        above;
        logic        below;
        logic        outside;
        logic        approach;
        logic [3:0]  limit;
        logic [1:0]  dir;
        next_cur = cur;
        d = '0; a = '0; s = '0; h = '0; up_t = '0; dn_t = '0;
        above = 1'b0; below = 1'b0; outside = 1'b0; approach = 1'b0;
        limit = '0; dir = '0;
        for (int c = 0; c < 2; c++)
        begin
            if (upd[c])
            begin
                d   = {2'b00, conv_data};
                a   = {2'b00, cur.avg[c]};
                s   = scale_sens(sens[c]);                        // [RULE5]
                dir = dir_mode[2*c +: 2];
                // Hysteresis only in adaptive mode
                h   = (adaptive_en[c] && hyst_en[c]) ? (s >> 2) : 18'h0; // [RULE7] [RULE8]
                if (adaptive_en[c])
                begin
                    // Thresholds around the average, pulled in toward it by the hysteresis while flagged
                    up_t  = cur.flag[c] ? a + s - h : a + s;
                    dn_t  = cur.flag[c] ? a - s + h : a - s;
                    above = $signed(d) > $signed(up_t);
                    below = $signed(d) < $signed(dn_t);
                    unique case (atd_pkg::atd_dir_t'(dir))
                        atd_pkg::ATD_POS:     next_cur.flag[c] = above;           // [RULE3]
                        atd_pkg::ATD_NEG:     next_cur.flag[c] = below;           // [RULE3]
                        atd_pkg::ATD_OUT_WIN: next_cur.flag[c] = above | below;   // [RULE4]
                        atd_pkg::ATD_IN_WIN:  next_cur.flag[c] = ~(above | below); // [RULE4]
                    endcase
                    // Timeout runs only outside average plus minus sensitivity
                    outside  = ($signed(d) > $signed(a + s)) || ($signed(d) < $signed(a - s)); // [RULE9]
                    approach = (dir == 2'(atd_pkg::ATD_NEG)) ? below : above;
                    limit    = approach ? appr[c] : rec[c];                  // [RULE11]
                    if (outside && limit != 4'h0)
                    begin
                        if (cur.tcount[c] + 4'h1 >= limit)
                        begin
                            // Snap average to data
                            next_cur.avg[c]    = conv_data;                  // [RULE10]
                            next_cur.tcount[c] = 4'h0;
                        end
                        else
                        begin
                            next_cur.tcount[c] = cur.tcount[c] + 4'h1;       // [RULE9]
                            next_cur.avg[c]    = avg_step(cur.avg[c], conv_data, shift[c]); // [RULE6]
                        end
                    end
                    else
                    begin
                        next_cur.tcount[c] = outside ? cur.tcount[c] : 4'h0;
                        next_cur.avg[c]    = avg_step(cur.avg[c], conv_data, shift[c]); // [RULE6]
                    end
                end
                else
                begin
                    // Fixed constant threshold, no hysteresis
                    if (dir[0])
                        next_cur.flag[c] = conv_data > fix_thr[c];      // [RULE2] [RULE3]
                    else
                        next_cur.flag[c] = conv_data < fix_thr[c];      // [RULE2] [RULE3]
                    next_cur.avg[c]    = avg_step(cur.avg[c], conv_data, shift[c]); // [RULE1]
                    next_cur.tcount[c] = 4'h0;
                end
            end
        end

        // Inactivity timer
        if (cur.pd)
        begin
            if (wake_sync)
                next_cur.pd = 1'b0;                                  // [RULE18]
            next_cur.prescale   = '0;
            next_cur.idle_ticks = '0;
        end
        else if (!pd_timer_en || (|cur.flag))
        begin
            next_cur.prescale   = '0;
            next_cur.idle_ticks = '0;
        end
        else if (cur.prescale == 24'(PD_UNIT_CYCLES - 1))
        begin
            next_cur.prescale   = '0;
            next_cur.idle_ticks = cur.idle_ticks + 6'h01;
            if (cur.idle_ticks + 6'h01 >= pd_timeout)
                next_cur.pd = 1'b1;                                  // [RULE17]
        end
        else
        begin
            next_cur.prescale = cur.prescale + 24'h000001;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (srst)
            cur <= '0;                                               // [RULE20]
        else
            cur <= next_cur;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign detect_flag_one       = cur.flag[0];                      // [RULE19]
    assign detect_flag_two       = cur.flag[1];                      // [RULE19]
    assign average_one           = cur.avg[0];
    assign average_two           = cur.avg[1];
    assign offset_cancel_dac_one = dac_out[0];
    assign offset_cancel_dac_two = dac_out[1];
    assign power_down            = cur.pd;

endmodule

`default_nettype wire

//--- verification/atd_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// --------
// Port checker for the threshold detector
// --------
module atd_asserts
(
    input wire logic        mclk,
    input wire logic        srst,
    input wire logic [15:0] conv_data,
    input wire logic        conv_done,
    input wire logic        conv_channel,
    input wire logic [1:0]  adaptive_en,
    input wire logic [3:0]  dir_mode,
    input wire logic [15:0] fixed_threshold_one,
    input wire logic [1:0]  dac_auto_en,
    input wire logic [1:0]  dac_load,
    input wire logic [5:0]  dac_load_value_one,
    input wire logic        pd_timer_en,
    input wire logic        host_wake,
    input wire logic        detect_flag_one,
    input wire logic        detect_flag_two,
    input wire logic [15:0] average_one,
    input wire logic [5:0]  offset_cancel_dac_one,
    input wire logic        power_down
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    logic take_one, auto_one, up_one, dn_one, fix_one; // Channel one events
    assign take_one = conv_done && !conv_channel && !power_down;
    assign auto_one = take_one && dac_auto_en[0] && adaptive_en[0] && !dac_load[0];
    assign up_one   = auto_one && (average_one > 16'hA800) && (offset_cancel_dac_one != 6'h3F);
    assign dn_one   = auto_one && (average_one < 16'h5800) && (offset_cancel_dac_one != 6'h00);
    assign fix_one  = take_one && !adaptive_en[0];
    chk_avg_idle: assert property (!take_one |=> $stable(average_one))
        else $error("avg one moved idle");
    chk_dac_idle: assert property (!take_one && !dac_load[0] |=> $stable(offset_cancel_dac_one))
        else $error("dac one moved idle");
    chk_dac_load: assert property (dac_load[0] |=> offset_cancel_dac_one == $past(dac_load_value_one))
        else $error("dac one load lost");
    chk_dac_up: assert property (up_one |=> offset_cancel_dac_one > $past(offset_cancel_dac_one))
        else $error("dac one did not step up");
    chk_dac_down: assert property (dn_one |=> offset_cancel_dac_one < $past(offset_cancel_dac_one))
        else $error("dac one did not step down");
    chk_fixed_cmp: assert property (fix_one |=> detect_flag_one == ($past(dir_mode[0]) ?
        ($past(conv_data) > $past(fixed_threshold_one)) : ($past(conv_data) < $past(fixed_threshold_one))))
        else $error("fixed compare wrong");
    chk_pd_refuse: assert property (power_down && conv_done |=> $stable(average_one))
        else $error("result taken while asleep");
    chk_pd_wake: assert property ($rose(host_wake) && power_down |-> ##[1:5] !power_down)
        else $error("host command did not wake");
    chk_pd_busy: assert property (detect_flag_one || detect_flag_two || !pd_timer_en |=> !$rose(power_down))
        else $error("early sleep");
    cov_sleep: cover property ($rose(power_down));
    cov_dac_up: cover property (up_one);
    cov_flag_two: cover property ($rose(detect_flag_two));
endmodule
bind adaptive_threshold_detector atd_asserts atd_asserts_i (.*);
`default_nettype wire

//--- verification/atd_sensor_model.sv
`timescale 1ns/1ps
`default_nettype none
// --------
// Sensor front end, one pulse per result
// --------
module atd_sensor_model
(
    input  wire logic        mclk,         // System clock
    output logic      [15:0] conv_data,    // Result, scrambled when idle
    output logic             conv_done,    // Result strobe
    output logic             conv_channel  // Channel of the result
);
    initial
    begin
        conv_data    = 16'h0000;
        conv_done    = 1'h0;
        conv_channel = 1'h0;
    end
    // Show one result for one cycle
    task automatic convert(input logic ch, input logic [15:0] d, input int gap);
        repeat (gap) @(posedge mclk);
        #1;
        conv_channel = ch;
        conv_data    = d;
        conv_done    = 1'h1;
        @(posedge mclk);
        #1;
        conv_done    = 1'h0;
        conv_data    = ~d;
        conv_channel = ~ch;
    endtask
endmodule
`default_nettype wire

//--- verification/adaptive_threshold_detector_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module adaptive_threshold_detector_tb_top;
    // --------
    // Stimulus and observed signals
    // --------
    logic        mclk = 1'h0, srst = 1'h1, pden = 1'h0, wake = 1'h0;
    logic [1:0]  aen = 2'h0, hyst = 2'h0, rng = 2'h0, dauto = 2'h0, dld = 2'h0;
    logic [3:0]  dir = 4'h0, appr = 4'h0, rec = 4'h0, setl = 4'h0;
    logic [7:0]  sens = 8'h00;
    logic [15:0] thr = 16'h8000;
    logic [5:0]  dv = 6'h00;
    logic [15:0] cd, a1, a2;
    logic        cdone, cch, f1, f2, pd;
    logic [5:0]  d1, d2;
    int          num_errors = 0;
    int          n_tests = 0;
    always #20 mclk = ~mclk;
    atd_sensor_model atd_sensor_model_i (.mclk(mclk), .conv_data(cd), .conv_done(cdone), .conv_channel(cch));
    adaptive_threshold_detector #(.PD_UNIT_CYCLES(4)) adaptive_threshold_detector_i
    (
        .mclk(mclk), .srst(srst), .conv_data(cd), .conv_done(cdone), .conv_channel(cch),
        .adaptive_en(aen), .dir_mode(dir), .fixed_threshold_one(thr), .fixed_threshold_two(thr),
        .sensitivity_one(sens), .sensitivity_two(8'h10), .approach_timeout_one(appr),
        .approach_timeout_two(appr), .recede_timeout_one(rec), .recede_timeout_two(rec),
        .average_settling_shift_one(setl), .average_settling_shift_two(4'h0), .hyst_en(hyst),
        .range_high(rng), .dac_auto_en(dauto), .dac_load(dld), .dac_load_value_one(dv),
        .dac_load_value_two(dv), .pd_timer_en(pden), .pd_timeout(6'h02), .host_wake(wake),
        .detect_flag_one(f1), .detect_flag_two(f2), .average_one(a1), .average_two(a2),
        .offset_cancel_dac_one(d1), .offset_cancel_dac_two(d2), .power_down(pd)
    );
    // --------
    // Shared helpers
    // --------
    task automatic tick();
        @(posedge mclk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cv(input logic ch, input logic [15:0] d, input int gap);
        atd_sensor_model_i.convert(ch, d, gap);
    endtask
    task automatic wait_pd(input logic v);
        for (int i = 0; i < 64 && pd !== v; i++)
            tick();
        if (pd !== v)
        begin
            num_errors++;
            final_report();
        end
    endtask
    task automatic final_report();
        $display("tests %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // --------
    // Scenarios
    // --------
    task automatic t_fixed();
        hyst = 2'h3; sens = 8'hFF; dir = 4'h5;
        cv(1'h0, 16'h8001, 1); chk("flag1 pos", f1, 1'h1);
        cv(1'h0, 16'h7FFF, 1); chk("flag1 pos", f1, 1'h0);
        dir = 4'h4;
        cv(1'h0, 16'h7FFF, 1); chk("flag1 neg", f1, 1'h1);
        cv(1'h1, 16'h9000, 0); chk("flag2 pos", f2, 1'h1);
        chk("flag1 kept", f1, 1'h1);
        cv(1'h0, 16'h8001, 1); chk("flag1 neg", f1, 1'h0);
        $display("t_fixed done");
    endtask
    task automatic t_avg();
        srst = 1'h1; repeat (2) tick(); srst = 1'h0;
        aen = 2'h1; dir = 4'h1; hyst = 2'h0;
        cv(1'h0, 16'h4000, 3); chk("avg1", a1, 16'h2000);
        setl = 4'h2;
        cv(1'h0, 16'h4000, 0); chk("avg1", a1, 16'h2400);
        setl = 4'h0;
        cv(1'h0, 16'h0000, 1); chk("avg1", a1, 16'h1200);
        chk("avg2", a2, 16'h0000);
        $display("t_avg done");
    endtask
    task automatic t_tout();
        setl = 4'hF; sens = 8'h01; dir = 4'h0; appr = 4'h1; rec = 4'h3;
        for (int i = 0; i < 3; i++)
        begin
            cv(1'h0, 16'h9000, 0); chk("avg1 recede", a1, (i < 2) ? 16'h1200 : 16'h9000);
        end
        cv(1'h0, 16'h8000, 1); chk("avg1 approach", a1, 16'h8000);
        for (int i = 0; i < 4; i++)
        begin
            cv(1'h0, 16'h8008, 0); chk("avg1 in band", a1, 16'h8000);
        end
        $display("t_tout done");
    endtask
    task automatic t_win();
        appr = 4'h0; rec = 4'h0; sens = 8'h10;
        for (int m = 2; m < 4; m++)
        begin
            dir = 4'(m);
            cv(1'h0, 16'h8050, 1); chk("flag1 window", f1, m == 2);
        end
        cv(1'h0, 16'h8200, 1); chk("flag1 out win", f1, 1'h1);
        dir = 4'h1; sens = 8'h40; hyst = 2'h1;
        cv(1'h0, 16'h8401, 1); chk("flag1 band", f1, 1'h1);
        cv(1'h0, 16'h83F0, 1); chk("flag1 hyst", f1, 1'h1);
        hyst = 2'h0;
        cv(1'h0, 16'h83F0, 1); chk("flag1 no hyst", f1, 1'h0);
        $display("t_win done");
    endtask
    task automatic t_dac();
        logic [5:0]  te [6] = '{6'h3E, 6'h3F, 6'h3F, 6'h3F, 6'h3E, 6'h3C};
        sens = 8'h00; appr = 4'h1; rec = 4'h1; dauto = 2'h1; dv = 6'h3E; dld = 2'h1;
        tick(); dld = 2'h0;
        chk("dac1 load", d1, 6'h3E);
        for (int i = 0; i < 6; i++)
        begin
            rng = {1'h0, i == 5};
            cv(1'h0, (i < 3) ? 16'hB000 : 16'h1000, 1); chk("dac1 auto", d1, te[i]);
        end
        chk("dac2 kept", d2, 6'h00);
        dv = 6'h01; dld = 2'h1;
        tick(); dld = 2'h0;
        cv(1'h0, 16'h1000, 1); chk("dac1 floor", d1, 6'h00);
        $display("t_dac done");
    endtask
    task automatic t_pd();
        aen = 2'h0; dir = 4'h5; dauto = 2'h0; rng = 2'h0;
        cv(1'h0, 16'h0000, 1);
        pden = 1'h1; wait_pd(1'h1); chk("asleep", pd, 1'h1);
        cv(1'h0, 16'h9000, 1); chk("flag1 refused", f1, 1'h0);
        pden = 1'h0; wake = 1'h1; tick(); wake = 1'h0;
        wait_pd(1'h0); chk("awake", pd, 1'h0);
        cv(1'h0, 16'h9000, 1); chk("flag1 awake", f1, 1'h1);
        $display("t_pd done");
    endtask
    initial
    begin
        repeat (16) tick();
        srst = 1'h0;
        t_fixed(); t_avg(); t_tout(); t_win(); t_dac(); t_pd();
        final_report();
    end
endmodule
`default_nettype wire
